// [hw/lbdc_pkg.sv]
/*
  Shared constants for the LED blink and dimming block: timing figures,
  register offsets, field positions, write masks and phase codes.
  Assumes a 250 MHz system clock and an 8-bit register port.
*/
package lbdc_pkg;

    // Clock rate and the three timing steps
    localparam int CLK_MHZ          = 250;
    localparam int SLOT_TIME_US     = 250;
    localparam int SLOT_CYCLES      = SLOT_TIME_US * CLK_MHZ;
    localparam int PWM_PERIOD_MS    = 8;
    localparam int SLOTS_PER_PERIOD = PWM_PERIOD_MS * 1000 / SLOT_TIME_US;
    localparam int STEP_TIME_MS     = 64;
    localparam int PERIODS_PER_STEP = STEP_TIME_MS / PWM_PERIOD_MS;

    // Register offsets
    localparam logic [7:0] OFS_SECOND_LED_RAMP_AND_CURRENT = 8'h4f;
    localparam logic [7:0] OFS_SECOND_LED_PHASE1_LENGTH    = 8'h50;
    localparam logic [7:0] OFS_SECOND_LED_PHASE2_LENGTH    = 8'h51;
    localparam logic [7:0] OFS_SECOND_LED_PHASE3_LENGTH    = 8'h52;
    localparam logic [7:0] OFS_SECOND_LED_PHASE4_LENGTH    = 8'h53;
    localparam logic [7:0] OFS_SECOND_LED_PAUSE_LENGTH     = 8'h54;
    localparam logic [7:0] OFS_SECOND_LED_DUTY_CYCLE       = 8'h55;
    localparam logic [7:0] OFS_SECOND_LED_ON_DURATION      = 8'h56;
    localparam logic [7:0] OFS_THIRD_LED_RAMP_AND_CURRENT  = 8'h57;
    localparam logic [7:0] OFS_THIRD_LED_PHASE1_LENGTH     = 8'h58;
    localparam logic [7:0] OFS_THIRD_LED_PHASE2_LENGTH     = 8'h59;
    localparam logic [7:0] OFS_SHARED_RISE_DURATION        = 8'h5f;
    localparam logic [7:0] OFS_SEQUENCER_STATUS            = 8'h6f;

    // Register array indices, counted from the first offset
    localparam int REG_COUNT = 11;
    localparam int IDX_B_CTRL = 0;
    localparam int IDX_B_T1   = 1;
    localparam int IDX_B_T2   = 2;
    localparam int IDX_B_T3   = 3;
    localparam int IDX_B_T4   = 4;
    localparam int IDX_B_TP   = 5;
    localparam int IDX_B_PWM  = 6;
    localparam int IDX_B_ON   = 7;
    localparam int IDX_C_CTRL = 8;
    localparam int IDX_C_T1   = 9;
    localparam int IDX_C_T2   = 10;

    // Writable bits per register; all others read as zero
    localparam logic [REG_COUNT-1:0][7:0] REG_MASK = {
        8'h7f, 8'h7f, 8'h2f, 8'h1f, 8'h1f, 8'h7f,
        8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h2f};
    localparam logic [7:0] RISE_MASK = 8'h1f;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions in the ramp and current registers and the status register
    localparam int RAMP_BIT  = 5;
    localparam int SINK_MSB  = 3;
    localparam int STAT_ON_BIT = 7;

    // Blink sequencer phases
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ON   = 3'b001,
        PH_T1   = 3'b010,
        PH_T2   = 3'b011,
        PH_T3   = 3'b100,
        PH_T4   = 3'b101,
        PH_TP   = 3'b110
    } lbdc_phase_type;

endpackage

// [hw/lbdc_tick_div.sv]
/*
  Enable-driven tick divider: emits one-cycle tick every DIV enables.
  Assumes en_in is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module lbdc_tick_div import lbdc_pkg::*; #(
    parameter int DIV = 2
) (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // Enable and tick
    input  wire logic en_in,
    output logic      tick_out
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } lbdc_div_state_type;

    lbdc_div_state_type st_r;
    lbdc_div_state_type st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (en_in) begin
            if (st_r.cnt == LAST) begin
                st_nxt.cnt  = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;
endmodule

// [hw/lbdc_led_blink.sv]
/*
  LED blink and dimming control: register file of the second channel and
  the start of the third, blink sequencer and PWM for the second channel.
  Assumes the serial control interface presents one-cycle read and write
  strobes with address and data on clk_sys_in.
*/
// What this block does
// RQ1: Power-on reset clears every control register
// RQ2: Reserved bits ignore writes, read zero
// RQ3: Phase one lasts count times 64 ms
// RQ4: Phase two lasts count times 64 ms
// RQ5: Phase three lasts count times 64 ms
// RQ6: Phase four lasts count times 64 ms
// RQ7: Pause lasts count times 64 ms
// RQ8: On-signal high (code+1)/32 of 8 ms
// RQ9: On-time lasts count times 64 ms
// RQ10: Third channel ramp enable at bit 5
// RQ11: Third channel sink level bits 3..0
// RQ12: Third channel phase one count bits 6..0
// RQ13: Second channel ramp bit 5, sink 3..0
// RQ14: Ramp-up lasts shared count times 8 ms
// RQ15: Common 250 us, 8 ms, 64 ms ticks
`timescale 1ns/1ps
module lbdc_led_blink import lbdc_pkg::*; #(
    parameter int SLOT_DIV = SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // Register port
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // Second channel
    output logic            second_led_on_signal_out,
    output logic            second_led_ramp_select_out,
    output logic      [3:0] second_led_sink_level_out,
    // Third channel
    output logic            third_led_ramp_select_out,
    output logic      [3:0] third_led_sink_level_out,
    output logic      [6:0] third_led_phase1_count_out,
    output logic      [6:0] third_led_phase2_count_out
);

    typedef struct packed {
        logic [REG_COUNT-1:0][7:0] regs;
        logic [7:0]                rise;
        logic [7:0]                rdata;
        lbdc_phase_type            phase;
        logic [6:0]                pcnt;
        logic [4:0]                slot;
        logic [4:0]                rcnt;
        logic                      on;
    } lbdc_state_type;

    lbdc_state_type st_r;
    lbdc_state_type st_nxt;

    logic       tick_slot;
    logic       tick_period;
    logic       tick_step;
    logic [7:0] off;
    logic       in_map;
    logic [6:0] len;
    logic       any_len;
    logic       lit;
    logic [4:0] duty;
    logic [4:0] rise5;
    logic       ramp_act;
    logic [4:0] duty_eff;
    logic [9:0] ramp_prod;

    // Tick chain; slower ticks trail by one cycle each
    lbdc_tick_div #(.DIV(SLOT_DIV)) u_slot_div (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .en_in      (1'b1),
        .tick_out   (tick_slot)
    ); // [RQ15]

    lbdc_tick_div #(.DIV(SLOTS_PER_PERIOD)) u_period_div (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .en_in      (tick_slot),
        .tick_out   (tick_period)
    ); // [RQ15]

    lbdc_tick_div #(.DIV(PERIODS_PER_STEP)) u_step_div (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .en_in      (tick_period),
        .tick_out   (tick_step)
    ); // [RQ15]

    function automatic lbdc_phase_type next_phase(lbdc_phase_type ph, logic any);
        case (ph)
            PH_ON:   next_phase = PH_T1;
            PH_T1:   next_phase = PH_T2;
            PH_T2:   next_phase = PH_T3;
            PH_T3:   next_phase = PH_T4;
            PH_T4:   next_phase = PH_TP;
            PH_TP:   next_phase = any ? PH_ON : PH_IDLE;
            default: next_phase = any ? PH_ON : PH_IDLE;
        endcase
    endfunction

    always_comb begin
        off    = reg_addr_in - OFS_SECOND_LED_RAMP_AND_CURRENT;
        in_map = (reg_addr_in >= OFS_SECOND_LED_RAMP_AND_CURRENT)
              && (reg_addr_in <= OFS_THIRD_LED_PHASE2_LENGTH);
        any_len = |{st_r.regs[IDX_B_ON][4:0], st_r.regs[IDX_B_T1][6:0],
                    st_r.regs[IDX_B_T2][6:0], st_r.regs[IDX_B_T3][6:0],
                    st_r.regs[IDX_B_T4][6:0], st_r.regs[IDX_B_TP][6:0]};
        case (st_r.phase)
            PH_ON:   len = {2'b00, st_r.regs[IDX_B_ON][4:0]}; // [RQ9]
            PH_T1:   len = st_r.regs[IDX_B_T1][6:0];          // [RQ3]
            PH_T2:   len = st_r.regs[IDX_B_T2][6:0];          // [RQ4]
            PH_T3:   len = st_r.regs[IDX_B_T3][6:0];          // [RQ5]
            PH_T4:   len = st_r.regs[IDX_B_T4][6:0];          // [RQ6]
            PH_TP:   len = st_r.regs[IDX_B_TP][6:0];          // [RQ7]
            default: len = 7'h00;
        endcase
        lit = (st_r.phase == PH_ON) || (st_r.phase == PH_T1)
           || (st_r.phase == PH_T3);
        duty  = st_r.regs[IDX_B_PWM][4:0];
        rise5 = st_r.rise[4:0];
        // Duty climbs linearly from zero to the code over the rise time
        ramp_act  = st_r.regs[IDX_B_CTRL][RAMP_BIT] && (st_r.rcnt < rise5); // [RQ14]
        ramp_prod = {5'h00, duty} * {5'h00, st_r.rcnt};
        duty_eff  = duty;
        if (ramp_act) begin
            duty_eff = 5'(ramp_prod / {5'h00, rise5}); // [RQ14]
        end
    end

    always_comb begin
        st_nxt = st_r;
        // Register writes, masked so reserved bits stay zero
        if (reg_wr_in) begin
            if (in_map) begin
                st_nxt.regs[off[3:0]] = reg_wdata_in & REG_MASK[off[3:0]]; // [RQ2]
            end else if (reg_addr_in == OFS_SHARED_RISE_DURATION) begin
                st_nxt.rise = reg_wdata_in & RISE_MASK; // [RQ2]
            end
        end
        // Read data registered; unmapped offsets read zero
        if (reg_rd_in) begin
            if (in_map) begin
                st_nxt.rdata = st_r.regs[off[3:0]];
            end else if (reg_addr_in == OFS_SHARED_RISE_DURATION) begin
                st_nxt.rdata = st_r.rise;
            end else if (reg_addr_in == OFS_SEQUENCER_STATUS) begin
                st_nxt.rdata = {st_r.on, 4'h0, st_r.phase};
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
        // Slot counter wraps every 8 ms period
        if (tick_slot) begin
            st_nxt.slot = st_r.slot + 5'h01; // [RQ8]
        end
        // Blink sequencer; a zero-length phase passes in one cycle
        case (st_r.phase)
            PH_IDLE: begin
                if (any_len) begin
                    st_nxt.phase = PH_ON;
                    st_nxt.pcnt  = 7'h00;
                    st_nxt.rcnt  = 5'h00;
                end
            end
            default: begin
                if (st_r.pcnt >= len) begin // [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ9]
                    st_nxt.phase = next_phase(st_r.phase, any_len);
                    st_nxt.pcnt  = 7'h00;
                    st_nxt.rcnt  = 5'h00;
                end else begin
                    if (tick_step) begin
                        st_nxt.pcnt = st_r.pcnt + 7'h01; // [RQ15]
                    end
                    if (lit && ramp_act && tick_period) begin
                        st_nxt.rcnt = st_r.rcnt + 5'h01; // [RQ14]
                    end
                end
            end
        endcase
        // On-signal is dark outside lit phases
        st_nxt.on = lit && (st_r.slot <= duty_eff); // [RQ8]
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= '0; // [RQ1]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out              = st_r.rdata;
    assign second_led_on_signal_out   = st_r.on;
    assign second_led_ramp_select_out = st_r.regs[IDX_B_CTRL][RAMP_BIT];     // [RQ13]
    assign second_led_sink_level_out  = st_r.regs[IDX_B_CTRL][SINK_MSB:0];   // [RQ13]
    assign third_led_ramp_select_out  = st_r.regs[IDX_C_CTRL][RAMP_BIT];     // [RQ10]
    assign third_led_sink_level_out   = st_r.regs[IDX_C_CTRL][SINK_MSB:0];   // [RQ11]
    assign third_led_phase1_count_out = st_r.regs[IDX_C_T1][6:0];            // [RQ12]
    assign third_led_phase2_count_out = st_r.regs[IDX_C_T2][6:0];

    // Checks

    property p_reset_clear;
        @(posedge clk_sys_in)
        rst_in |=> (st_r.regs == '0) && (st_r.rise == REG_RESET)
                   && (st_r.phase == PH_IDLE) && !second_led_on_signal_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Registers not cleared"); // [RQ1]

    property p_rsvd_zero;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_rd_in && in_map) |=> (reg_rdata_out & ~REG_MASK[$past(off[3:0])]) == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bit read nonzero"); // [RQ2]

    property p_phase1_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        (st_r.phase == PH_T1)
            |-> ((st_r.pcnt >= st_r.regs[IDX_B_T1][6:0]) == (st_nxt.phase != PH_T1));
    endproperty
    a_phase1_len: assert property (p_phase1_len) else $error("Phase one length wrong"); // [RQ3]

    property p_phase2_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        (st_r.phase == PH_T2)
            |-> ((st_r.pcnt >= st_r.regs[IDX_B_T2][6:0]) == (st_nxt.phase != PH_T2));
    endproperty
    a_phase2_len: assert property (p_phase2_len) else $error("Phase two length wrong"); // [RQ4]

    property p_phase3_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        (st_r.phase == PH_T3)
            |-> ((st_r.pcnt >= st_r.regs[IDX_B_T3][6:0]) == (st_nxt.phase != PH_T3));
    endproperty
    a_phase3_len: assert property (p_phase3_len) else $error("Phase three length wrong"); // [RQ5]

    property p_phase4_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        (st_r.phase == PH_T4)
            |-> ((st_r.pcnt >= st_r.regs[IDX_B_T4][6:0]) == (st_nxt.phase != PH_T4));
    endproperty
    a_phase4_len: assert property (p_phase4_len) else $error("Phase four length wrong"); // [RQ6]

    property p_pause_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        (st_r.phase == PH_TP)
            |-> ((st_r.pcnt >= st_r.regs[IDX_B_TP][6:0]) == (st_nxt.phase != PH_TP));
    endproperty
    a_pause_len: assert property (p_pause_len) else $error("Pause length wrong"); // [RQ7]

    property p_duty_full;
        @(posedge clk_sys_in) disable iff (rst_in)
        (lit && !ramp_act && duty == 5'h1f) |=> second_led_on_signal_out;
    endproperty
    a_duty_full: assert property (p_duty_full) else $error("Full code not steady high"); // [RQ8]

    property p_duty_low;
        @(posedge clk_sys_in) disable iff (rst_in)
        (!ramp_act && duty == 5'h00 && st_r.slot != 5'h00) |=> !second_led_on_signal_out;
    endproperty
    a_duty_low: assert property (p_duty_low) else $error("Code zero high too long"); // [RQ8]

    property p_on_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        (st_r.phase == PH_ON)
            |-> ((st_r.pcnt >= {2'b00, st_r.regs[IDX_B_ON][4:0]}) == (st_nxt.phase != PH_ON));
    endproperty
    a_on_len: assert property (p_on_len) else $error("On-time length wrong"); // [RQ9]

    property p_third_ramp;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == OFS_THIRD_LED_RAMP_AND_CURRENT)
            |=> third_led_ramp_select_out == $past(reg_wdata_in[RAMP_BIT]);
    endproperty
    a_third_ramp: assert property (p_third_ramp) else $error("Third ramp bit wrong"); // [RQ10]

    property p_third_sink;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == OFS_THIRD_LED_RAMP_AND_CURRENT)
            |=> third_led_sink_level_out == $past(reg_wdata_in[SINK_MSB:0]);
    endproperty
    a_third_sink: assert property (p_third_sink) else $error("Third sink level wrong"); // [RQ11]

    property p_third_t1;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == OFS_THIRD_LED_PHASE1_LENGTH)
            |=> third_led_phase1_count_out == $past(reg_wdata_in[6:0]);
    endproperty
    a_third_t1: assert property (p_third_t1) else $error("Third phase one wrong"); // [RQ12]

    property p_second_ctrl;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == OFS_SECOND_LED_RAMP_AND_CURRENT)
            |=> (second_led_ramp_select_out == $past(reg_wdata_in[RAMP_BIT]))
                && (second_led_sink_level_out == $past(reg_wdata_in[SINK_MSB:0]));
    endproperty
    a_second_ctrl: assert property (p_second_ctrl) else $error("Second ctrl wrong"); // [RQ13]

    sequence s_ramp_step;
        lit && ramp_act && tick_period && (st_nxt.phase == st_r.phase);
    endsequence

    property p_ramp_step;
        @(posedge clk_sys_in) disable iff (rst_in)
        s_ramp_step |=> st_r.rcnt == $past(st_r.rcnt) + 5'h01;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("Ramp did not step"); // [RQ14]

    property p_step_sync;
        @(posedge clk_sys_in) disable iff (rst_in)
        tick_step |-> $past(tick_period) && $past(tick_slot, 2);
    endproperty
    a_step_sync: assert property (p_step_sync) else $error("Ticks out of step"); // [RQ15]

    // Slot count wraps to zero as the period tick fires, so PWM and steps never drift apart
    property p_slot_wrap;
        @(posedge clk_sys_in) disable iff (rst_in)
        tick_period |-> (st_r.slot == 5'h00);
    endproperty
    a_slot_wrap: assert property (p_slot_wrap) else $error("Slot count off period"); // [RQ15]

    property p_unmapped_zero;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_rd_in && !in_map && (reg_addr_in != OFS_SHARED_RISE_DURATION)
            && (reg_addr_in != OFS_SEQUENCER_STATUS)) |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read nonzero"); // [RQ2]

    property p_dark_phase;
        @(posedge clk_sys_in) disable iff (rst_in)
        !lit |=> !second_led_on_signal_out;
    endproperty
    a_dark_phase: assert property (p_dark_phase) else $error("On-signal high when dark"); // [RQ8]

    property p_rise_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == OFS_SHARED_RISE_DURATION)
            |=> st_r.rise == ($past(reg_wdata_in) & RISE_MASK);
    endproperty
    a_rise_write: assert property (p_rise_write) else $error("Rise duration wrong"); // [RQ14]

endmodule

// [tb/testbench.sv]
/*
  Self-checking bench for the LED blink and dimming block: register
  reset values, reserved bits, field outputs, duty cycle of the second
  channel's on-signal and lengths of the lit and dark blink phases.
  Assumes the one-cycle strobe register port and a 250 MHz clock; the
  slot divider is cut to 4 cycles so that one 64 ms step is 1024 cycles.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("ERROR at %0t ns: got %h, expected %h", $time, (got), (exp)); \
    end \
end

module testbench;

    localparam int SD = 4;
    localparam int ST = 32 * SD * 8;
    localparam logic [7:0] OFS [12] = '{8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54,
                                        8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5f};
    localparam logic [7:0] MSK [12] = '{8'h2f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f,
                                        8'h1f, 8'h1f, 8'h2f, 8'h7f, 8'h7f, 8'h1f};
    // Lit and dark phase pairs: on-time/phase2, phase1/phase4, phase3/pause
    localparam logic [7:0] LIT [3] = '{8'h56, 8'h50, 8'h52};
    localparam logic [7:0] DRK [3] = '{8'h51, 8'h53, 8'h54};
    localparam logic [4:0] DUTY [3] = '{5'h00, 5'h07, 5'h1f};

    logic       clk_sys_in;
    logic       rst_in;
    logic       reg_wr_in;
    logic       reg_rd_in;
    logic [7:0] reg_addr_in;
    logic [7:0] reg_wdata_in;
    logic [7:0] reg_rdata_out;
    logic       on_sig;
    logic       s_ramp;
    logic [3:0] s_sink;
    logic       t_ramp;
    logic [3:0] t_sink;
    logic [6:0] t_p1;
    logic [6:0] t_p2;
    int         mismatches;
    int         checks_done;

    lbdc_led_blink #(
        .SLOT_DIV (SD)
    ) lbdc_led_blink_inst (
        .clk_sys_in                 (clk_sys_in),
        .rst_in                     (rst_in),
        .reg_wr_in                  (reg_wr_in),
        .reg_rd_in                  (reg_rd_in),
        .reg_addr_in                (reg_addr_in),
        .reg_wdata_in               (reg_wdata_in),
        .reg_rdata_out              (reg_rdata_out),
        .second_led_on_signal_out   (on_sig),
        .second_led_ramp_select_out (s_ramp),
        .second_led_sink_level_out  (s_sink),
        .third_led_ramp_select_out  (t_ramp),
        .third_led_sink_level_out   (t_sink),
        .third_led_phase1_count_out (t_p1),
        .third_led_phase2_count_out (t_p2)
    );

    always #2 clk_sys_in = ~clk_sys_in;

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk_sys_in);
        rst_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        rst_in = 1'b0;
    endtask

    // Strobe for one cycle; one idle cycle between accesses keeps drivers clean
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_in  = a;
        reg_wdata_in = d;
        reg_wr_in    = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_rd_in   = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
    endtask

    // Run ends once the other level holds 8 cycles, so one-cycle zero phases are ignored
    task automatic run_len(input logic lvl, output int n);
        int k;
        n = 0;
        k = 0;
        while (k < 8 && n < 9000) begin
            @(negedge clk_sys_in);
            n++;
            if (on_sig === lvl) k = 0;
            else k++;
        end
        n = n - k;
    endtask

    initial begin
        #320us;
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [7:0] d;
        int         hi;
        int         h;
        int         l;
        clk_sys_in   = 1'b0;
        rst_in       = 1'b1;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        reg_addr_in  = 8'h00;
        reg_wdata_in = 8'h00;
        mismatches   = 0;
        checks_done  = 0;
        do_reset();
        hi = 0;
        repeat (200) begin
            @(negedge clk_sys_in);
            if (on_sig !== 1'b0) hi++;
        end
        `CHK(hi, 0)
        for (int i = 0; i < 12; i++) begin
            rd(OFS[i], d);
            `CHK(d, 8'h00)
            wr(OFS[i], 8'hff);
            rd(OFS[i], d);
            `CHK(d, MSK[i])
        end
        `CHK({s_ramp, s_sink, t_ramp, t_sink}, {1'b1, 4'hf, 1'b1, 4'hf})
        `CHK({t_p1, t_p2}, 14'h3fff)
        wr(8'h57, 8'he5);
        wr(8'h4f, 8'hda);
        wr(8'h58, 8'hb3);
        wr(8'h59, 8'h4c);
        `CHK({s_ramp, s_sink, t_ramp, t_sink}, {1'b0, 4'ha, 1'b1, 4'h5})
        `CHK({t_p1, t_p2}, {7'h33, 7'h4c})
        rd(8'h57, d);
        `CHK(d, 8'h25)
        // Unmapped offset must stay silent
        wr(8'h60, 8'hff);
        rd(8'h60, d);
        `CHK(d, 8'h00)
        do_reset();
        for (int i = 0; i < 12; i++) begin
            rd(OFS[i], d);
            `CHK(d, 8'h00)
        end
        `CHK({s_ramp, s_sink, t_ramp, t_sink, t_p1, t_p2}, 24'h000000)
        rd(8'h6f, d);
        `CHK(d, 8'h00)
        // Long on-time keeps the channel lit while the duty is measured
        wr(8'h56, 8'h1f);
        for (int c = 0; c < 3; c++) begin
            wr(8'h55, {3'b000, DUTY[c]});
            repeat (140) @(negedge clk_sys_in);
            hi = 0;
            repeat (32 * SD) begin
                @(negedge clk_sys_in);
                if (on_sig === 1'b1) hi++;
            end
            `CHK(hi, (int'(DUTY[c]) + 1) * SD)
        end
        // Rise of 4 periods: dim periods after the phase start, then full duty
        do_reset();
        wr(8'h5f, 8'h04);
        wr(8'h4f, 8'h20);
        wr(8'h55, 8'h1f);
        wr(8'h56, 8'h1f);
        hi = 0;
        repeat (5 * 32 * SD) begin
            @(negedge clk_sys_in);
            if (on_sig === 1'b1) hi++;
        end
        `CHK(hi >= 310 && hi <= 460, 1'b1)
        hi = 0;
        repeat (32 * SD) begin
            @(negedge clk_sys_in);
            if (on_sig === 1'b1) hi++;
        end
        `CHK(hi, 32 * SD)
        // Step ticks run free, so a phase of N steps lasts between N-1 and N steps
        for (int p = 0; p < 3; p++) begin
            do_reset();
            wr(8'h55, 8'h1f);
            wr(LIT[p], 8'h03);
            wr(DRK[p], 8'h02);
            run_len(1'b1, h);
            run_len(1'b0, l);
            run_len(1'b1, h);
            run_len(1'b0, l);
            `CHK(h > 2 * ST && h <= 3 * ST + 16, 1'b1)
            `CHK(l > ST && l <= 2 * ST + 16, 1'b1)
        end
        give_verdict();
    end

endmodule
